/* File: rtl/pmbc_defs.vh */
// Constants for the power mode and brownout control block.
// Assumes a 50 MHz sys_clk and a 32-bit classic Wishbone register bus.
`ifndef PMBC_DEFS_VH
`define PMBC_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
`define PMBC_CLK_NS 20
`define PMBC_WAKE_NS 200
`define PMBC_WAKE_CYC ((`PMBC_WAKE_NS + `PMBC_CLK_NS - 1) / `PMBC_CLK_NS)
`define PMBC_REG_SETTLE_NS 2000
`define PMBC_REG_SETTLE_CYC ((`PMBC_REG_SETTLE_NS + `PMBC_CLK_NS - 1) / `PMBC_CLK_NS)

////////////////////////////////////////////////////////////////////////////////
// Byte addresses on the bus
`define PMBC_ADR_MODE 8'h00
`define PMBC_ADR_PERIPH 8'h04
`define PMBC_ADR_BROWNOUT_CONFIG_REG 8'h08
`define PMBC_ADR_RESET_SOURCE_REG 8'h0c
`define PMBC_ADR_REGCTL 8'h10
`define PMBC_ADR_STATUS 8'h14

////////////////////////////////////////////////////////////////////////////////
// Mode request codes
`define PMBC_REQ_NONE 2'h0
`define PMBC_REQ_IDLE 2'h1
`define PMBC_REQ_PD 2'h2
`define PMBC_REQ_TPD 2'h3

// Peripheral switch-off bits
`define PMBC_OFF_WDT 0
`define PMBC_OFF_CMP 1
`define PMBC_OFF_RTC 2

// Brownout config fields
`define PMBC_BOI_LVL_HI 2
`define PMBC_BOI_LVL_LO 0
`define PMBC_BOI_EN 3
`define PMBC_LVL_MAX 3'h5

// User configuration word field for the brownout reset level
`define PMBC_UCFG_BOR_HI 5
`define PMBC_UCFG_BOR_LO 3

// Reset source flags
`define PMBC_RS_POF 0
`define PMBC_RS_BOF 1
`define PMBC_RS_WDT 2
`define PMBC_RS_SW 3
`define PMBC_RS_EXT 4
`define PMBC_RS_BRK 5
`define PMBC_RS_POR_VAL 6'h03

// Regulator control fields
`define PMBC_RC_REGULATOR_LOW_CURRENT_SEL 0
`define PMBC_RC_DONE 1

`endif

/* File: rtl/pmbc_bod_hyst.v */
// One brownout condition latch with separate falling and rising trip inputs.
// Assumes the monitor flags are synchronous to sys_clk.
`include "pmbc_defs.vh"

module pmbc_bod_hyst (
  input wire sys_clk,
  input wire reset,
  input wire enable,
  input wire below_fall,
  input wire above_rise,
  output reg cond_r
);

  reg cond_nxt;

  always @* begin
    cond_nxt = cond_r;
    if (!enable) begin
      cond_nxt = 1'b0;
    end else if (below_fall) begin
      cond_nxt = 1'b1;
    end else if (above_rise) begin
      cond_nxt = 1'b0;
    end
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cond_r <= 1'b0;
    end else begin
      cond_r <= cond_nxt;
    end
  end

endmodule // pmbc_bod_hyst

/* File: rtl/pmbc_reg_switch.v */
// Regulator mode switch: reports when high-speed operation is settled.
// Assumes the low-current select comes from a register in sys_clk domain.
`include "pmbc_defs.vh"

module pmbc_reg_switch (
  input wire sys_clk,
  input wire reset,
  input wire low_current_sel,
  output reg switch_done_r
);

  localparam integer SETTLE_FULL = `PMBC_REG_SETTLE_CYC;
  localparam [7:0] SETTLE = SETTLE_FULL[7:0];

  reg [7:0] cnt_r;
  reg [7:0] cnt_nxt;
  reg switch_done_nxt;

  always @* begin
    cnt_nxt = cnt_r;
    switch_done_nxt = switch_done_r;
    if (low_current_sel) begin
      cnt_nxt = SETTLE;
      switch_done_nxt = 1'b0;
    end else if (cnt_r != 8'h00) begin
      cnt_nxt = cnt_r - 8'h01;
      switch_done_nxt = (cnt_r == 8'h01);
    end
  end

  // High-speed after power-on, so done starts set
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 8'h00;
      switch_done_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      switch_done_r <= switch_done_nxt;
    end
  end

endmodule // pmbc_reg_switch

/* File: rtl/pmbc_top.v */
// Power mode sequencer, peripheral gating, brownout supervisor, reset flags.
// Assumes synchronous monitor and event inputs; reset is the power-on reset.
//
// What this block does
// - Idle, power-down and total power-down, each entered by software write.
// - Software can switch off each peripheral separately.
// - Regulators go to lowest setting automatically in any reduced mode.
// - Brownout gives reset request, interrupt request and flash inhibit.
// - All brownout functions inactive in power-down and total power-down.
// - Brownout reset and flash inhibit always on in normal and idle.
// - Brownout interrupt has its own software enable.
// - Reset and interrupt trip levels each have six settings.
// - Reset trip level from bits 5:3 of the user config word.
// - Interrupt trip level from a three-bit field in brownout config.
// - Flash inhibit uses one fixed level and blocks program and erase.
// - Condition sets below falling point, clears above rising point.
// - Power-on flag set at power-up, held until software clears it.
// - Idle halts the CPU and sets the regulators low; enabled interrupt or reset ends it.
// - Power-down stops main oscillator; reset or wake interrupt exits.
// - Watchdog, comparators, timer run in power-down unless switched off.
// - RC oscillator off in power-down unless system clock with timer on.
// - Total power-down turns off brownout, comparators and RC oscillator.
// - Software picks regulator mode in normal and idle.
// - Clearing low-current select starts switch; done flag rises when settled.
// - Power-on reset sets power-on and brownout flags, clears the rest.
`include "pmbc_defs.vh"

module pmbc_top (
  input wire sys_clk,
  input wire reset,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire [7:0] user_config_word,
  input wire irq_pending,
  input wire wake_irq,
  input wire rc_is_sysclk,
  input wire wdt_rst_evt,
  input wire sw_rst_evt,
  input wire ext_rst_evt,
  input wire brk_rst_evt,
  input wire bor_below_fall,
  input wire bor_above_rise,
  input wire boi_below_fall,
  input wire boi_above_rise,
  input wire bof_below_fall,
  input wire bof_above_rise,
  output wire [2:0] brownout_reset_level_sel,
  output wire [2:0] brownout_irq_level_sel,
  output wire bor_mon_en,
  output wire boi_mon_en,
  output wire bof_mon_en,
  output wire bod_reset_req,
  output wire bod_irq,
  output wire flash_inhibit,
  output wire cpu_halt,
  output wire main_osc_en,
  output wire rc_osc_en,
  output wire wdt_en,
  output wire cmp_en,
  output wire rtc_en,
  output wire [4:0] periph_en,
  output wire reg_deep_low,
  output wire reg_low_current,
  output wire [4:0] power_state
);

  localparam [4:0] ST_RUN = 5'h01;
  localparam [4:0] ST_IDLE = 5'h02;
  localparam [4:0] ST_PD = 5'h04;
  localparam [4:0] ST_TPD = 5'h08;
  localparam [4:0] ST_WAKE = 5'h10;
  localparam integer WAKE_CYC_FULL = `PMBC_WAKE_CYC;
  localparam [3:0] WAKE_CYC = WAKE_CYC_FULL[3:0];

  // Clamp a three-bit level code onto the six usable settings
  function [2:0] lvl_clamp;
    input [2:0] code;
    begin
      lvl_clamp = (code > `PMBC_LVL_MAX) ? `PMBC_LVL_MAX : code;
    end
  endfunction
  function sel_hit;
    input [7:0] adr;
    input [7:0] target;
    begin
      sel_hit = (adr == target);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave: ack one cycle after the request, dropped the next cycle

  reg ack_r;
  wire bus_req;
  wire wr_stb;
  wire wr_lane;

  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wb_ack_o = ack_r;
  assign wr_stb = ack_r & bus_req & wb_we_i;
  assign wr_lane = wr_stb & wb_sel_i[0];

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req & ~ack_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Software registers

  reg [1:0] mode_req_r;
  reg [7:0] periph_off_r;
  reg [3:0] brownout_config_reg_r;
  reg [5:0] reset_source_reg_r;
  reg [5:0] reset_source_reg_nxt;
  reg regulator_low_current_sel_r;
  wire switch_done;
  reg [4:0] state_r;
  reg [4:0] state_nxt;

  wire wr_mode = wr_lane & sel_hit(wb_adr_i, `PMBC_ADR_MODE);
  wire wr_periph = wr_lane & sel_hit(wb_adr_i, `PMBC_ADR_PERIPH);
  wire wr_brownout_config_reg = wr_lane & sel_hit(wb_adr_i, `PMBC_ADR_BROWNOUT_CONFIG_REG);
  wire wr_reset_source_reg = wr_lane & sel_hit(wb_adr_i, `PMBC_ADR_RESET_SOURCE_REG);
  wire wr_regctl = wr_lane & sel_hit(wb_adr_i, `PMBC_ADR_REGCTL);

  // A mode request is latched at the completing edge and acted on later
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode_req_r <= `PMBC_REQ_NONE;
    end else if (wr_mode && state_r == ST_RUN) begin
      mode_req_r <= wb_dat_i[1:0];
    end else begin
      mode_req_r <= `PMBC_REQ_NONE;
    end
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      periph_off_r <= 8'h00;
      brownout_config_reg_r <= 4'h0;
    end else begin
      if (wr_periph) begin
        periph_off_r <= wb_dat_i[7:0];
      end
      if (wr_brownout_config_reg) begin
        brownout_config_reg_r <= wb_dat_i[3:0];
      end
    end
  end

  // Regulator select only takes software writes in normal and idle
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      regulator_low_current_sel_r <= 1'b0;
    end else if (wr_regctl && (state_r == ST_RUN || state_r == ST_IDLE)) begin
      regulator_low_current_sel_r <= wb_dat_i[`PMBC_RC_REGULATOR_LOW_CURRENT_SEL];
    end
  end

  pmbc_reg_switch u_reg_switch (
    .sys_clk(sys_clk),
    .reset(reset),
    .low_current_sel(regulator_low_current_sel_r),
    .switch_done_r(switch_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Brownout supervisor

  wire bod_active;
  wire bor_cond;
  wire boi_cond;
  wire bof_cond;
  reg bor_req_d_r;

  // Off in both power-down modes, on otherwise
  assign bod_active = ~(state_r == ST_PD || state_r == ST_TPD);
  assign bor_mon_en = bod_active;
  assign bof_mon_en = bod_active;
  assign boi_mon_en = bod_active & brownout_config_reg_r[`PMBC_BOI_EN];
  assign brownout_reset_level_sel =
    lvl_clamp(user_config_word[`PMBC_UCFG_BOR_HI:`PMBC_UCFG_BOR_LO]);
  assign brownout_irq_level_sel =
    lvl_clamp(brownout_config_reg_r[`PMBC_BOI_LVL_HI:`PMBC_BOI_LVL_LO]);

  pmbc_bod_hyst u_bor (
    .sys_clk(sys_clk),
    .reset(reset),
    .enable(bor_mon_en),
    .below_fall(bor_below_fall),
    .above_rise(bor_above_rise),
    .cond_r(bor_cond)
  );

  pmbc_bod_hyst u_boi (
    .sys_clk(sys_clk),
    .reset(reset),
    .enable(boi_mon_en),
    .below_fall(boi_below_fall),
    .above_rise(boi_above_rise),
    .cond_r(boi_cond)
  );

  // Fixed level: no select output for this one
  pmbc_bod_hyst u_bof (
    .sys_clk(sys_clk),
    .reset(reset),
    .enable(bof_mon_en),
    .below_fall(bof_below_fall),
    .above_rise(bof_above_rise),
    .cond_r(bof_cond)
  );

  assign bod_reset_req = bor_cond;
  assign bod_irq = boi_cond;
  assign flash_inhibit = bof_cond;

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bor_req_d_r <= 1'b0;
    end else begin
      bor_req_d_r <= bor_cond;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reset source flags: a new event beats a software clear

  always @* begin
    reset_source_reg_nxt = reset_source_reg_r;
    if (wr_reset_source_reg) begin
      reset_source_reg_nxt = reset_source_reg_r & wb_dat_i[5:0];
    end
    if (sw_rst_evt) begin
      reset_source_reg_nxt[`PMBC_RS_SW] = 1'b1;
    end
    if (ext_rst_evt) begin
      reset_source_reg_nxt[`PMBC_RS_EXT] = 1'b1;
    end
    if (brk_rst_evt) begin
      reset_source_reg_nxt[`PMBC_RS_BRK] = 1'b1;
    end
    if (bor_cond && !bor_req_d_r) begin
      reset_source_reg_nxt[`PMBC_RS_BOF] = 1'b1;
    end
    // Watchdog reset behaves like power-on for the flags
    if (wdt_rst_evt) begin
      reset_source_reg_nxt = `PMBC_RS_POR_VAL;
    end
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reset_source_reg_r <= `PMBC_RS_POR_VAL;
    end else begin
      reset_source_reg_r <= reset_source_reg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power state sequencer

  reg [3:0] wake_cnt_r;
  reg [3:0] wake_cnt_nxt;
  wire any_rst_evt;

  assign any_rst_evt = wdt_rst_evt | sw_rst_evt | ext_rst_evt | brk_rst_evt | bor_cond;

  always @* begin
    state_nxt = state_r;
    wake_cnt_nxt = wake_cnt_r;
    case (state_r)
      ST_RUN: begin
        case (mode_req_r)
          `PMBC_REQ_IDLE: state_nxt = ST_IDLE;
          `PMBC_REQ_PD: state_nxt = ST_PD;
          `PMBC_REQ_TPD: state_nxt = ST_TPD;
          default: state_nxt = ST_RUN;
        endcase
      end
      ST_IDLE: begin
        if (irq_pending || any_rst_evt) begin
          state_nxt = ST_WAKE;
          wake_cnt_nxt = WAKE_CYC;
        end
      end
      ST_PD, ST_TPD: begin
        if (wake_irq || any_rst_evt) begin
          state_nxt = ST_WAKE;
          wake_cnt_nxt = WAKE_CYC;
        end
      end
      ST_WAKE: begin
        // Oscillator and regulator settle before the CPU fetches again
        if (wake_cnt_r == 4'h1) begin
          state_nxt = ST_RUN;
        end
        wake_cnt_nxt = wake_cnt_r - 4'h1;
      end
      default: begin
        state_nxt = ST_RUN;
        wake_cnt_nxt = 4'h0;
      end
    endcase
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= ST_RUN;
      wake_cnt_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      wake_cnt_r <= wake_cnt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, analog and regulator controls

  wire in_pd = (state_r == ST_PD);
  wire in_tpd = (state_r == ST_TPD);
  wire in_run_idle = (state_r == ST_RUN) || (state_r == ST_IDLE);

  assign power_state = state_r;
  assign cpu_halt = (state_r != ST_RUN);
  assign main_osc_en = ~(in_pd | in_tpd);
  assign wdt_en = ~periph_off_r[`PMBC_OFF_WDT];
  assign rtc_en = ~periph_off_r[`PMBC_OFF_RTC];
  assign cmp_en = ~periph_off_r[`PMBC_OFF_CMP] & ~in_tpd;
  // Other peripherals lose their clock with the main oscillator anyway
  assign periph_en = ~periph_off_r[7:3] & {5{main_osc_en}};

  // Total power-down forces it off even with the timer on the RC clock
  assign rc_osc_en = main_osc_en | (in_pd & rc_is_sysclk & rtc_en);

  assign reg_deep_low = (state_r == ST_IDLE) | in_pd | in_tpd;
  assign reg_low_current = regulator_low_current_sel_r & in_run_idle;

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, captured on the first cycle of a request

  reg [31:0] rd_nxt;

  always @* begin
    rd_nxt = 32'h0000_0000;
    case (wb_adr_i)
      `PMBC_ADR_MODE: rd_nxt[4:0] = state_r;
      `PMBC_ADR_PERIPH: rd_nxt[7:0] = periph_off_r;
      `PMBC_ADR_BROWNOUT_CONFIG_REG: rd_nxt[3:0] = brownout_config_reg_r;
      `PMBC_ADR_RESET_SOURCE_REG: rd_nxt[5:0] = reset_source_reg_r;
      `PMBC_ADR_REGCTL: rd_nxt[1:0] = {switch_done, regulator_low_current_sel_r};
      `PMBC_ADR_STATUS: rd_nxt[2:0] = {bof_cond, boi_cond, bor_cond};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !ack_r) begin
      wb_dat_o <= rd_nxt;
    end
  end

endmodule // pmbc_top

/* File: testbench/pmbc_asserts.sv */
// Checker for the power mode and brownout block, bound to pmbc_top.
// Assumes one sys_clk domain and an active high asynchronous reset.
module pmbc_asserts (
  input wire sys_clk,
  input wire reset,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire rc_is_sysclk,
  input wire bof_below_fall,
  input wire bof_above_rise,
  input wire bor_mon_en,
  input wire boi_mon_en,
  input wire bof_mon_en,
  input wire bod_irq,
  input wire flash_inhibit,
  input wire cpu_halt,
  input wire main_osc_en,
  input wire rc_osc_en,
  input wire cmp_en,
  input wire rtc_en,
  input wire reg_deep_low,
  input wire [4:0] power_state
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////////
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request left without ack");
  a_low_bod_off: assert property ((power_state[2] || power_state[3]) |->
    !bor_mon_en && !boi_mon_en && !bof_mon_en) else $error("brownout active in power-down");
  a_run_bod_on: assert property ((power_state[0] || power_state[1]) |->
    bor_mon_en && bof_mon_en) else $error("brownout reset or flash off");
  a_reg_deep: assert property (reg_deep_low == (|power_state[3:1]))
    else $error("regulator setting wrong for state");
  a_pd_clocks: assert property (power_state[2] |-> !main_osc_en &&
    (rc_osc_en == (rc_is_sysclk && rtc_en))) else $error("power-down clocks wrong");
  a_tpd_off: assert property (power_state[3] |-> !rc_osc_en && !cmp_en)
    else $error("total power-down left analog on");
  a_inhibit_set: assert property (bof_below_fall && bof_mon_en |=> flash_inhibit)
    else $error("flash inhibit missed low supply");
  a_inhibit_hold: assert property (flash_inhibit && bof_mon_en && !bof_above_rise
    |=> flash_inhibit) else $error("flash inhibit released early");
  a_irq_gate: assert property (!boi_mon_en |=> !bod_irq)
    else $error("brownout irq while disabled");
  a_halt_idle: assert property (cpu_halt == !power_state[0])
    else $error("cpu halt wrong for state");
  a_wake_len: assert property ($rose(power_state[4]) |->
    ##9 power_state[4] ##1 power_state[0]) else $error("wake span wrong");

  c_idle_wake: cover property (power_state[1] ##1 power_state[4]);
  c_total_pd: cover property (power_state[3]);
  c_low_supply: cover property (flash_inhibit && bod_irq);
endmodule // pmbc_asserts

/* File: testbench/pmbc_supply_mon.sv */
// Behavioural supply monitors: reset, interrupt and flash comparator pairs.
// Assumes the bench sets the supply in millivolts away from clock edges.
module pmbc_supply_mon #(
  parameter int BOR_FALL = 2600,
  parameter int BOR_RISE = 2700,
  parameter int BOI_FALL = 2900,
  parameter int BOI_RISE = 3000,
  parameter int BOF_FALL = 2400,
  parameter int BOF_RISE = 2500
) (
  input wire sys_clk,
  input wire [11:0] vdd_mv,
  input wire bor_mon_en,
  input wire boi_mon_en,
  input wire bof_mon_en,
  output logic bor_below_fall = 1'h0,
  output logic bor_above_rise = 1'h0,
  output logic boi_below_fall = 1'h0,
  output logic boi_above_rise = 1'h0,
  output logic bof_below_fall = 1'h0,
  output logic bof_above_rise = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic junk_r = 1'h0;

  // A disabled comparator gives no usable level, so it chatters
  always @(posedge sys_clk) begin
    junk_r <= ~junk_r;
    bor_below_fall <= bor_mon_en ? (vdd_mv < BOR_FALL) : junk_r;
    bor_above_rise <= bor_mon_en ? (vdd_mv > BOR_RISE) : ~junk_r;
    boi_below_fall <= boi_mon_en ? (vdd_mv < BOI_FALL) : junk_r;
    boi_above_rise <= boi_mon_en ? (vdd_mv > BOI_RISE) : ~junk_r;
    bof_below_fall <= bof_mon_en ? (vdd_mv < BOF_FALL) : junk_r;
    bof_above_rise <= bof_mon_en ? (vdd_mv > BOF_RISE) : ~junk_r;
  end
endmodule // pmbc_supply_mon

/* File: testbench/pmbc_tb_top.sv */
// Self-checking bench for pmbc_top with the supply monitor model.
// Assumes ack one cycle after a request and a ten cycle wake span.
`define PMBC_CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
  mismatches++; $display("BAD %s exp %0h got %0h", nm, exp, got); end end
module pmbc_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'h0, reset = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [7:0] wb_adr_i = 8'h00, user_config_word = 8'h00;
  logic [3:0] wb_sel_i = 4'h0, evt = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, q;
  logic irq_pending = 1'h0, wake_irq = 1'h0, rc_is_sysclk = 1'h0;
  logic [11:0] vdd = 12'hc1c;
  wire [31:0] wb_dat_o;
  wire [2:0] brownout_reset_level_sel, brownout_irq_level_sel;
  wire [4:0] periph_en, power_state;
  wire wb_ack_o, bor_below_fall, bor_above_rise, boi_below_fall, boi_above_rise;
  wire bof_below_fall, bof_above_rise, bor_mon_en, boi_mon_en, bof_mon_en, bod_reset_req;
  wire bod_irq, flash_inhibit, cpu_halt, main_osc_en, rc_osc_en, wdt_en, cmp_en, rtc_en;
  wire reg_deep_low, reg_low_current;
  int mismatches = 0;
  int comparisons = 0;

  always #10 sys_clk = ~sys_clk;

  pmbc_top pmbc_top_inst (.sys_clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .user_config_word, .irq_pending, .wake_irq,
    .rc_is_sysclk, .wdt_rst_evt(evt[0]), .sw_rst_evt(evt[1]), .ext_rst_evt(evt[2]),
    .brk_rst_evt(evt[3]), .bor_below_fall, .bor_above_rise, .boi_below_fall,
    .boi_above_rise, .bof_below_fall, .bof_above_rise, .brownout_reset_level_sel,
    .brownout_irq_level_sel, .bor_mon_en, .boi_mon_en, .bof_mon_en, .bod_reset_req, .bod_irq,
    .flash_inhibit, .cpu_halt, .main_osc_en, .rc_osc_en, .wdt_en, .cmp_en, .rtc_en,
    .periph_en, .reg_deep_low, .reg_low_current, .power_state);

  // Reset trip kept below the interrupt trip, as software should
  pmbc_supply_mon pmbc_supply_mon_inst (.sys_clk, .vdd_mv(vdd), .bor_mon_en, .boi_mon_en,
    .bof_mon_en, .bor_below_fall, .bor_above_rise, .boi_below_fall, .boi_above_rise,
    .bof_below_fall, .bof_above_rise);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    // Ack and read data are taken at the rising edge that sees ack high
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    q = wb_dat_o;
    if (n >= 20) mismatches++;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
    // Callers look at outputs only after the write has landed
    @(negedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(1'h0, a, 32'h0);
  endtask

  task automatic pulse(input logic [3:0] v);
    @(posedge sys_clk);
    evt <= v;
    @(posedge sys_clk);
    evt <= 4'h0;
  endtask

  task automatic wait_state(input logic [4:0] s);
    int n;
    n = 0;
    while (power_state !== s && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 300) mismatches++;
  endtask

  task automatic supply(input logic [11:0] mv);
    @(posedge sys_clk);
    vdd <= mv;
    repeat (4) @(negedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(8'h0c); `PMBC_CHK("reset_source", 32'h3, q)
    rd(8'h0c); `PMBC_CHK("reset_source", 32'h3, q)
    rd(8'h00); `PMBC_CHK("mode", 32'h1, q)
    rd(8'h10); `PMBC_CHK("regctl", 32'h2, q)
    wr(8'h20, 32'hff);
    rd(8'h20); `PMBC_CHK("unmapped", 32'h0, q)
    wr(8'h0c, 32'h01);
    rd(8'h0c); `PMBC_CHK("reset_source", 32'h1, q)
    pulse(4'h2);
    pulse(4'h8);
    rd(8'h0c); `PMBC_CHK("reset_source", 32'h29, q)
    pulse(4'h1);
    rd(8'h0c); `PMBC_CHK("reset_source", 32'h3, q)
  endtask

  task automatic t_levels;
    for (int c = 0; c < 8; c++) begin
      @(posedge sys_clk);
      user_config_word <= {2'h0, c[2:0], 3'h0};
      wr(8'h08, {29'h0, c[2:0]});
      `PMBC_CHK("bor_level", (c > 5) ? 3'h5 : c[2:0], brownout_reset_level_sel)
      `PMBC_CHK("boi_level", (c > 5) ? 3'h5 : c[2:0], brownout_irq_level_sel)
    end
  endtask

  task automatic t_idle;
    wr(8'h00, 32'h1);
    wait_state(5'h02);
    `PMBC_CHK("state", 5'h02, power_state)
    `PMBC_CHK("main_osc", 1'h1, main_osc_en)
    `PMBC_CHK("deep_low", 1'h1, reg_deep_low)
    @(posedge sys_clk);
    irq_pending <= 1'h1;
    wait_state(5'h10);
    @(posedge sys_clk);
    irq_pending <= 1'h0;
    wait_state(5'h01);
    `PMBC_CHK("halt", 1'h0, cpu_halt)
  endtask

  task automatic t_pd;
    @(posedge sys_clk);
    rc_is_sysclk <= 1'h1;
    wr(8'h04, 32'h09);
    `PMBC_CHK("periph_en", 5'h1e, periph_en)
    wr(8'h00, 32'h2);
    wait_state(5'h04);
    `PMBC_CHK("wdt_en", 1'h0, wdt_en)
    `PMBC_CHK("cmp_en", 1'h1, cmp_en)
    `PMBC_CHK("rtc_en", 1'h1, rtc_en)
    `PMBC_CHK("rc_osc", 1'h1, rc_osc_en)
    `PMBC_CHK("periph_en", 5'h00, periph_en)
    @(posedge sys_clk);
    rc_is_sysclk <= 1'h0;
    @(negedge sys_clk);
    `PMBC_CHK("rc_osc", 1'h0, rc_osc_en)
    @(posedge sys_clk);
    wake_irq <= 1'h1;
    wait_state(5'h10);
    @(posedge sys_clk);
    wake_irq <= 1'h0;
    wait_state(5'h01);
    `PMBC_CHK("main_osc", 1'h1, main_osc_en)
    wr(8'h04, 32'h0);
  endtask

  task automatic t_tpd;
    @(posedge sys_clk);
    rc_is_sysclk <= 1'h1;
    wr(8'h00, 32'h3); // Timer left on, as if fed from a slow clock
    wait_state(5'h08);
    `PMBC_CHK("rc_osc", 1'h0, rc_osc_en)
    `PMBC_CHK("cmp_en", 1'h0, cmp_en)
    `PMBC_CHK("rtc_en", 1'h1, rtc_en)
    wr(8'h00, 32'h1);
    rd(8'h00); `PMBC_CHK("mode", 32'h08, q)
    pulse(4'h4);
    wait_state(5'h01);
    `PMBC_CHK("state", 5'h01, power_state)
    @(posedge sys_clk);
    rc_is_sysclk <= 1'h0;
    rd(8'h0c); `PMBC_CHK("reset_source", 32'h13, q)
  endtask

  task automatic t_bod;
    wr(8'h0c, 32'h0);
    wr(8'h08, 32'h05);
    supply(12'haf0);
    `PMBC_CHK("bod_irq", 1'h0, bod_irq)
    wr(8'h08, 32'h0d);
    supply(12'haf0);
    `PMBC_CHK("bod_irq", 1'h1, bod_irq)
    supply(12'h8fc);
    `PMBC_CHK("inhibit", 1'h1, flash_inhibit)
    rd(8'h14); `PMBC_CHK("status", 32'h7, q)
    rd(8'h0c); `PMBC_CHK("reset_source", 32'h2, q)
    supply(12'h992);
    `PMBC_CHK("inhibit", 1'h1, flash_inhibit)
    wr(8'h08, 32'h0);
    `PMBC_CHK("bod_reset", 1'h1, bod_reset_req)
    supply(12'hc1c);
    `PMBC_CHK("inhibit", 1'h0, flash_inhibit)
    `PMBC_CHK("bod_reset", 1'h0, bod_reset_req)
  endtask

  task automatic t_reg;
    int n;
    wr(8'h10, 32'h1);
    `PMBC_CHK("low_current", 1'h1, reg_low_current)
    rd(8'h10); `PMBC_CHK("regctl", 32'h1, q)
    wr(8'h10, 32'h0);
    n = 0;
    do begin
      rd(8'h10);
      n++;
    end while (q[1] !== 1'h1 && n < 60);
    `PMBC_CHK("regctl", 32'h2, q)
    `PMBC_CHK("settle_reads", 1'h1, n > 20)
  endtask

  task final_report;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'h0;
    t_regs;
    t_levels;
    t_idle;
    t_pd;
    t_tpd;
    t_bod;
    t_reg;
    final_report;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    final_report;
  end
endmodule // pmbc_tb_top

bind pmbc_top pmbc_asserts pmbc_asserts_inst (.sys_clk, .reset, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .rc_is_sysclk, .bof_below_fall, .bof_above_rise, .bor_mon_en, .boi_mon_en,
  .bof_mon_en, .bod_irq, .flash_inhibit, .cpu_halt, .main_osc_en, .rc_osc_en, .cmp_en,
  .rtc_en, .reg_deep_low, .power_state);
